/* File: shared/srp_pkg.sv */
// Constants and carrier types for the receive pin and transmit timer control block
package srp_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] SRP_OFF_PIN_CTRL   = 8'h00;
	localparam logic [7:0] SRP_OFF_TMR_CTRL   = 8'h04;
	localparam logic [7:0] SRP_OFF_TMR_COUNT  = 8'h08;
	localparam logic [7:0] SRP_OFF_TMR_PERIOD = 8'h0C;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [31:0] SRP_RST_WORD   = 32'h0000_0000;
	localparam logic [15:0] SRP_RST_HALF   = 16'h0000;
	localparam logic [5:0]  SRP_RST_RXTMR  = 6'h00;
	localparam logic [2:0]  SRP_RST_SYNC   = 3'h0;

	// ************************************************************
	// Pin control fields (pin k uses bits 4k+3..4k)
	// ************************************************************
	localparam int SRP_NUM_PINS   = 3;
	localparam int SRP_PIN_STRIDE = 4;
	localparam int SRP_PIN_FUNC   = 0;
	localparam int SRP_PIN_DIR    = 1;
	localparam int SRP_PIN_DOUT   = 2;
	localparam int SRP_PIN_DIN    = 3;
	localparam int SRP_IDX_CLK    = 0;
	localparam int SRP_IDX_DATA   = 1;
	localparam int SRP_IDX_SYNC   = 2;
	localparam int SRP_IDX_TXCLK  = 3;
	localparam int SRP_NUM_SYNC   = 4;
	localparam int SRP_SYNC_STAGES = 3;

	// ************************************************************
	// Timer control fields
	// ************************************************************
	localparam int SRP_TMR_GO     = 0;
	localparam int SRP_TMR_HOLD_N = 1;
	localparam int SRP_TMR_CP     = 2;
	localparam int SRP_TMR_SRC    = 3;
	localparam int SRP_TMR_FLAG   = 5;
	localparam int SRP_TMR_RX_LO  = 6;
	localparam int SRP_TMR_RX_HI  = 11;
	localparam int SRP_CNT_W      = 16;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} srp_apb_req_t;

	typedef struct packed {
		logic func;
		logic dir;
		logic dout;
	} srp_pin_cfg_t;

endpackage

/* File: hw/srp_top.sv */
// Receive pin control and transmit timer control with APB register access

// Behaviour
// [R1] Clock pin: function bit picks GPIO or port
// [R2] Clock pin direction: 0 input, 1 output
// [R3] Clock pin output drives data-out bit
// [R4] Clock pin data-in reads pin, read-only
// [R5] Data pin: function bit picks GPIO or port
// [R6] Data pin direction: 0 input, 1 output
// [R7] Data pin output drives data-out bit
// [R8] Data pin data-in reads pin, read-only
// [R9] Sync pin: function bit picks GPIO or port
// [R10] Sync pin direction: 0 input, 1 output
// [R11] Sync pin output drives data-out bit
// [R12] Sync pin data-in reads pin, read-only
// [R13] Pin register 32 bits, zero reset, reserved zero
// [R14] Timer control 32 bits, zero at reset
// [R15] Bits 5..0 transmit, 11..6 receive timer
// [R16] Timer counter is sixteen bits wide
// [R17] Restart zeroes counter, counts from next tick
// [R18] Restart self-clears on tick; zero write ignored
// [R19] Hold low freezes counter value
// [R20] Hold also freezes divide-by-two prescaler
// [R21] Clock mode: output toggles, half duty
// [R22] Pulse mode: one-cycle pulse each period
// [R23] Source bit: half clock or synced pin
// [R24] Flag follows output, rise interrupts, read-only
// [R25] Counter wraps to zero at period, reset zero
// [R26] Writes act next clock; restart waits tick
module srp_top (
	input  wire logic                 mclk,
	input  wire logic                 reset,
	input  wire srp_pkg::srp_apb_req_t apb_req,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	input  wire logic                 receive_clock_pin_in,
	output logic                      receive_clock_pin_out,
	output logic                      receive_clock_pin_oe,
	input  wire logic                 receive_data_pin_in,
	output logic                      receive_data_pin_out,
	output logic                      receive_data_pin_oe,
	input  wire logic                 receive_frame_sync_pin_in,
	output logic                      receive_frame_sync_pin_out,
	output logic                      receive_frame_sync_pin_oe,
	input  wire logic                 transmit_clock_pin_in,
	input  wire logic [2:0]           port_pin_out,
	input  wire logic [2:0]           port_pin_oe,
	output logic [2:0]                port_pin_level,
	output logic                      tx_timer_out,
	output logic                      tx_timer_irq
);

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
		addr_hit = (a == off);
	endfunction

	function automatic logic [3:0] pin_nibble(input srp_pkg::srp_pin_cfg_t c, input logic lvl);
		logic [3:0] n;
		n = 4'h0;
		n[srp_pkg::SRP_PIN_FUNC] = c.func;
		n[srp_pkg::SRP_PIN_DIR]  = c.dir;
		n[srp_pkg::SRP_PIN_DOUT] = c.dout;
		n[srp_pkg::SRP_PIN_DIN]  = lvl;
		pin_nibble = n;
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	srp_pkg::srp_pin_cfg_t                  pin_cfg_reg [srp_pkg::SRP_NUM_PINS];
	srp_pkg::srp_pin_cfg_t                  pin_cfg_next [srp_pkg::SRP_NUM_PINS];
	logic [2:0]                             sync_reg [srp_pkg::SRP_NUM_SYNC];
	logic [2:0]                             sync_next [srp_pkg::SRP_NUM_SYNC];
	logic [srp_pkg::SRP_NUM_SYNC-1:0]       lvl_reg;
	logic [srp_pkg::SRP_NUM_SYNC-1:0]       lvl_next;
	logic                                   txclk_prev_reg;
	logic                                   txclk_prev_next;
	logic [2:0]                             pin_out_reg;
	logic [2:0]                             pin_out_next;
	logic [2:0]                             pin_oe_reg;
	logic [2:0]                             pin_oe_next;
	logic                                   go_reg;
	logic                                   go_next;
	logic                                   hold_n_reg;
	logic                                   hold_n_next;
	logic                                   cp_reg;
	logic                                   cp_next;
	logic                                   src_reg;
	logic                                   src_next;
	logic [5:0]                             rxtmr_reg;
	logic [5:0]                             rxtmr_next;
	logic                                   presc_reg;
	logic                                   presc_next;
	logic [srp_pkg::SRP_CNT_W-1:0]          count_reg;
	logic [srp_pkg::SRP_CNT_W-1:0]          count_next;
	logic [srp_pkg::SRP_CNT_W-1:0]          period_reg;
	logic [srp_pkg::SRP_CNT_W-1:0]          period_next;
	logic                                   flag_reg;
	logic                                   flag_next;
	logic                                   irq_reg;
	logic                                   irq_next;
	logic                                   pready_reg;
	logic                                   pready_next;
	logic [31:0]                            prdata_reg;
	logic [31:0]                            prdata_next;
	logic                                   pslverr_reg;
	logic                                   pslverr_next;

	// ************************************************************
	// Combinational signals
	// ************************************************************
	logic [srp_pkg::SRP_NUM_SYNC-1:0]       pin_raw;
	logic [2:0]                             port_lvl;
	logic                                   access;
	logic                                   wr_done;
	logic                                   mapped;
	logic [31:0]                            pin_word;
	logic [31:0]                            tmr_word;
	logic [31:0]                            rd_word;
	logic                                   tick;
	logic                                   wrap;
	logic [srp_pkg::SRP_CNT_W-1:0]          count_inc;

	assign pin_raw[srp_pkg::SRP_IDX_CLK]  = receive_clock_pin_in;
	assign pin_raw[srp_pkg::SRP_IDX_DATA] = receive_data_pin_in;
	assign pin_raw[srp_pkg::SRP_IDX_SYNC] = receive_frame_sync_pin_in;
	assign pin_raw[srp_pkg::SRP_IDX_TXCLK] = transmit_clock_pin_in;
	assign port_lvl = lvl_reg[2:0];

	// ************************************************************
	// Register read images
	// ************************************************************
	always_comb begin
		pin_word = srp_pkg::SRP_RST_WORD;
		// [R4] Data-in reads level
		// [R8] Data-in reads level
		// [R12] Data-in reads level
		// [R13] Reserved bits read zero
		for (int k = 0; k < srp_pkg::SRP_NUM_PINS; k++) begin
			pin_word[k*srp_pkg::SRP_PIN_STRIDE +: 4] = pin_nibble(pin_cfg_reg[k], port_lvl[k]);
		end
		tmr_word = srp_pkg::SRP_RST_WORD;
		// [R15] Transmit and receive fields
		tmr_word[srp_pkg::SRP_TMR_GO]     = go_reg;
		tmr_word[srp_pkg::SRP_TMR_HOLD_N] = hold_n_reg;
		tmr_word[srp_pkg::SRP_TMR_CP]     = cp_reg;
		tmr_word[srp_pkg::SRP_TMR_SRC]    = src_reg;
		tmr_word[srp_pkg::SRP_TMR_FLAG]   = flag_reg;
		tmr_word[srp_pkg::SRP_TMR_RX_HI:srp_pkg::SRP_TMR_RX_LO] = rxtmr_reg;
	end

	always_comb begin
		mapped = 1'b1;
		rd_word = srp_pkg::SRP_RST_WORD;
		if (addr_hit(apb_req.paddr, srp_pkg::SRP_OFF_PIN_CTRL)) begin
			rd_word = pin_word;
		end else if (addr_hit(apb_req.paddr, srp_pkg::SRP_OFF_TMR_CTRL)) begin
			rd_word = tmr_word;
		end else if (addr_hit(apb_req.paddr, srp_pkg::SRP_OFF_TMR_COUNT)) begin
			rd_word[srp_pkg::SRP_CNT_W-1:0] = count_reg;
		end else if (addr_hit(apb_req.paddr, srp_pkg::SRP_OFF_TMR_PERIOD)) begin
			rd_word[srp_pkg::SRP_CNT_W-1:0] = period_reg;
		end else begin
			mapped = 1'b0;
		end
	end

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		access  = apb_req.psel && apb_req.penable;
		wr_done = access && pready_reg && apb_req.pwrite && mapped;

		// APB slave: one wait cycle, then completion
		pready_next  = access && !pready_reg;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		if (access && !pready_reg) begin
			prdata_next  = apb_req.pwrite ? srp_pkg::SRP_RST_WORD : rd_word;
			pslverr_next = !mapped;
		end
	end

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	always_comb begin
		// Three-stage synchronisers, change taken when last two stages agree
		for (int k = 0; k < srp_pkg::SRP_NUM_SYNC; k++) begin
			sync_next[k] = {sync_reg[k][1:0], pin_raw[k]};
			lvl_next[k] = (sync_reg[k][1] == sync_reg[k][2]) ? sync_reg[k][2] : lvl_reg[k];
		end
	end

	// ************************************************************
	// Pin configuration
	// ************************************************************
	always_comb begin
		// Pin configuration writes
		for (int k = 0; k < srp_pkg::SRP_NUM_PINS; k++) begin
			pin_cfg_next[k] = pin_cfg_reg[k];
			if (wr_done && addr_hit(apb_req.paddr, srp_pkg::SRP_OFF_PIN_CTRL)) begin
				// [R4] Data-in write ignored
				pin_cfg_next[k].func = apb_req.pwdata[k*srp_pkg::SRP_PIN_STRIDE + srp_pkg::SRP_PIN_FUNC];
				pin_cfg_next[k].dir  = apb_req.pwdata[k*srp_pkg::SRP_PIN_STRIDE + srp_pkg::SRP_PIN_DIR];
				pin_cfg_next[k].dout = apb_req.pwdata[k*srp_pkg::SRP_PIN_STRIDE + srp_pkg::SRP_PIN_DOUT];
			end
		end

		// Pin drive selection
		// [R1] Clock pin function mux
		// [R2] Direction selects enable
		// [R3] Drive data-out bit
		// [R5] Data pin function mux
		// [R6] Direction selects enable
		// [R7] Drive data-out bit
		// [R9] Sync pin function mux
		// [R10] Direction selects enable
		// [R11] Drive data-out bit
		for (int k = 0; k < srp_pkg::SRP_NUM_PINS; k++) begin
			pin_out_next[k] = pin_cfg_reg[k].func ? port_pin_out[k] : pin_cfg_reg[k].dout;
			pin_oe_next[k]  = pin_cfg_reg[k].func ? port_pin_oe[k]  : pin_cfg_reg[k].dir;
		end
	end

	// ************************************************************
	// Transmit timer
	// ************************************************************
	always_comb begin
		// Timer control writes
		go_next     = go_reg;
		hold_n_next = hold_n_reg;
		cp_next     = cp_reg;
		src_next    = src_reg;
		rxtmr_next  = rxtmr_reg;
		period_next = period_reg;
		txclk_prev_next = lvl_reg[srp_pkg::SRP_IDX_TXCLK];

		// [R23] Internal half rate or pin edge
		tick = hold_n_reg && (src_reg ? presc_reg
			: (lvl_reg[srp_pkg::SRP_IDX_TXCLK] && !txclk_prev_reg));

		// [R20] Prescaler frozen in hold
		presc_next = hold_n_reg ? !presc_reg : presc_reg;

		// [R16] Sixteen-bit counter step
		count_inc = count_reg + 16'h0001;
		// [R25] Wrap when reaching period
		wrap = tick && !go_reg && (count_inc == period_reg);
		count_next = count_reg;
		// [R17] Restart zeroes on tick
		// [R19] Hold keeps counter
		if (tick && go_reg) begin
			count_next = srp_pkg::SRP_RST_HALF;
		end else if (tick) begin
			count_next = wrap ? srp_pkg::SRP_RST_HALF : count_inc;
		end

		// [R18] Restart clears on tick
		if (tick) begin
			go_next = 1'b0;
		end

		if (wr_done && addr_hit(apb_req.paddr, srp_pkg::SRP_OFF_TMR_CTRL)) begin
			// [R26] Restart pending until tick; set wins
			if (apb_req.pwdata[srp_pkg::SRP_TMR_GO]) begin
				go_next = 1'b1;
			end
			hold_n_next = apb_req.pwdata[srp_pkg::SRP_TMR_HOLD_N];
			cp_next     = apb_req.pwdata[srp_pkg::SRP_TMR_CP];
			src_next    = apb_req.pwdata[srp_pkg::SRP_TMR_SRC];
			rxtmr_next  = apb_req.pwdata[srp_pkg::SRP_TMR_RX_HI:srp_pkg::SRP_TMR_RX_LO];
		end
		if (wr_done && addr_hit(apb_req.paddr, srp_pkg::SRP_OFF_TMR_COUNT)) begin
			count_next = apb_req.pwdata[srp_pkg::SRP_CNT_W-1:0];
		end
		if (wr_done && addr_hit(apb_req.paddr, srp_pkg::SRP_OFF_TMR_PERIOD)) begin
			period_next = apb_req.pwdata[srp_pkg::SRP_CNT_W-1:0];
		end

		// [R21] Clock mode toggles
		// [R22] Pulse mode single cycle
		if (cp_reg) begin
			flag_next = wrap ? !flag_reg : flag_reg;
		end else begin
			flag_next = wrap;
		end

		// [R24] Interrupt on flag rise
		irq_next = flag_next && !flag_reg;
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge mclk) begin
		if (reset) begin
			// [R13] Pin register clears
			for (int k = 0; k < srp_pkg::SRP_NUM_PINS; k++) begin
				pin_cfg_reg[k] <= '0;
			end
			for (int k = 0; k < srp_pkg::SRP_NUM_SYNC; k++) begin
				sync_reg[k] <= srp_pkg::SRP_RST_SYNC;
			end
			lvl_reg        <= '0;
			txclk_prev_reg <= 1'b0;
			pin_out_reg    <= 3'h0;
			pin_oe_reg     <= 3'h0;
			// [R14] Timer control clears
			go_reg         <= 1'b0;
			hold_n_reg     <= 1'b0;
			cp_reg         <= 1'b0;
			src_reg        <= 1'b0;
			rxtmr_reg      <= srp_pkg::SRP_RST_RXTMR;
			presc_reg      <= 1'b0;
			// [R25] Counter zero at reset
			count_reg      <= srp_pkg::SRP_RST_HALF;
			period_reg     <= srp_pkg::SRP_RST_HALF;
			flag_reg       <= 1'b0;
			irq_reg        <= 1'b0;
			pready_reg     <= 1'b0;
			prdata_reg     <= srp_pkg::SRP_RST_WORD;
			pslverr_reg    <= 1'b0;
		end else begin
			for (int k = 0; k < srp_pkg::SRP_NUM_PINS; k++) begin
				pin_cfg_reg[k] <= pin_cfg_next[k];
			end
			for (int k = 0; k < srp_pkg::SRP_NUM_SYNC; k++) begin
				sync_reg[k] <= sync_next[k];
			end
			lvl_reg        <= lvl_next;
			txclk_prev_reg <= txclk_prev_next;
			pin_out_reg    <= pin_out_next;
			pin_oe_reg     <= pin_oe_next;
			go_reg         <= go_next;
			hold_n_reg     <= hold_n_next;
			cp_reg         <= cp_next;
			src_reg        <= src_next;
			rxtmr_reg      <= rxtmr_next;
			presc_reg      <= presc_next;
			count_reg      <= count_next;
			period_reg     <= period_next;
			flag_reg       <= flag_next;
			irq_reg        <= irq_next;
			pready_reg     <= pready_next;
			prdata_reg     <= prdata_next;
			pslverr_reg    <= pslverr_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign pready                     = pready_reg;
	assign prdata                     = prdata_reg;
	assign pslverr                    = pslverr_reg;
	assign receive_clock_pin_out      = pin_out_reg[srp_pkg::SRP_IDX_CLK];
	assign receive_clock_pin_oe       = pin_oe_reg[srp_pkg::SRP_IDX_CLK];
	assign receive_data_pin_out       = pin_out_reg[srp_pkg::SRP_IDX_DATA];
	assign receive_data_pin_oe        = pin_oe_reg[srp_pkg::SRP_IDX_DATA];
	assign receive_frame_sync_pin_out = pin_out_reg[srp_pkg::SRP_IDX_SYNC];
	assign receive_frame_sync_pin_oe  = pin_oe_reg[srp_pkg::SRP_IDX_SYNC];
	assign port_pin_level             = port_lvl;
	assign tx_timer_out               = flag_reg;
	assign tx_timer_irq               = irq_reg;

endmodule

/* File: verif/srp_chk.sv */
// Port assertions for the receive pin and timer block
module srp_chk (
	input	wire logic			mclk,
	input	wire logic			reset,
	input	wire srp_pkg::srp_apb_req_t	apb_req,
	input	wire logic			pready,
	input	wire logic [31:0]		prdata,
	input	wire logic			pslverr,
	input	wire logic			receive_clock_pin_in,
	input	wire logic			receive_clock_pin_out,
	input	wire logic			receive_clock_pin_oe,
	input	wire logic			receive_data_pin_in,
	input	wire logic			receive_data_pin_out,
	input	wire logic			receive_data_pin_oe,
	input	wire logic			receive_frame_sync_pin_in,
	input	wire logic			receive_frame_sync_pin_out,
	input	wire logic			receive_frame_sync_pin_oe,
	input	wire logic			transmit_clock_pin_in,
	input	wire logic [2:0]		port_pin_out,
	input	wire logic [2:0]		port_pin_oe,
	input	wire logic [2:0]		port_pin_level,
	input	wire logic			tx_timer_out,
	input	wire logic			tx_timer_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Bus checks
	// ****************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	property p_ready_wait;
		apb_req.psel && apb_req.penable && !pready |=> pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready late");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
	property p_err_ready;
		pslverr |-> pready && prdata == 32'h0000_0000;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("pslverr bad");
	// ****************
	// Timer and pins
	// ****************
	// flag rise
	property p_irq_rise;
		tx_timer_irq |-> tx_timer_out && !$past(tx_timer_out);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq without rise");
	property p_irq_cause;
		$rose(tx_timer_out) |-> tx_timer_irq;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("rise without irq");
	property p_reset_pins;
		$fell(reset) |-> !(receive_clock_pin_oe || receive_data_pin_oe || receive_frame_sync_pin_oe);
	endproperty
	a_reset_pins: assert property (p_reset_pins) else $error("pin driven after reset");
	property p_reset_timer;
		$fell(reset) |-> !tx_timer_out && !tx_timer_irq && !pready;
	endproperty
	a_reset_timer: assert property (p_reset_timer) else $error("timer active after reset");
	property p_lvl_clk;
		((!reset && receive_clock_pin_in) [*5] |-> port_pin_level[0]) and
		((!reset && !receive_clock_pin_in) [*5] |-> !port_pin_level[0]);
	endproperty
	a_lvl_clk: assert property (p_lvl_clk) else $error("clock pin level");
	property p_lvl_dat;
		((!reset && receive_data_pin_in) [*5] |-> port_pin_level[1]) and
		((!reset && !receive_data_pin_in) [*5] |-> !port_pin_level[1]);
	endproperty
	a_lvl_dat: assert property (p_lvl_dat) else $error("data pin level");
	property p_lvl_fs;
		((!reset && receive_frame_sync_pin_in) [*5] |-> port_pin_level[2]) and
		((!reset && !receive_frame_sync_pin_in) [*5] |-> !port_pin_level[2]);
	endproperty
	a_lvl_fs: assert property (p_lvl_fs) else $error("sync pin level");
endmodule

/* File: verif/srp_peer.sv */
// External peripheral driving the three receive pins
module srp_peer (
	input	wire logic [2:0]	dev_out,
	input	wire logic [2:0]	dev_oe,
	input	wire logic [2:0]	ext_val,
	output	logic [2:0]		level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Wire level, device wins while driving
	always_comb level = (dev_oe & dev_out) | (~dev_oe & ext_val);
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the receive pin and timer block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0]	a;
		logic [31:0]	d;
		logic [31:0]	q;
		logic		e;
	} srp_row_t;
	localparam int PER = 3;
	logic			mclk;
	logic			reset;
	srp_pkg::srp_apb_req_t	req;
	logic			pready, pslverr, e, tx_clk, tmr_out, tmr_irq;
	logic [31:0]		prdata, q, q0;
	wire [2:0]		dev_out, dev_oe;
	logic [2:0]		lvl, port_out, port_oe, port_lvl, ext_val;
	int			err_total = 0, comparisons = 0, cycles = 0, n, h;
	srp_row_t		rows [6];

	srp_top u_dut (
		.mclk(mclk), .reset(reset), .apb_req(req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.receive_clock_pin_in(lvl[0]), .receive_clock_pin_out(dev_out[0]), .receive_clock_pin_oe(dev_oe[0]),
		.receive_data_pin_in(lvl[1]), .receive_data_pin_out(dev_out[1]), .receive_data_pin_oe(dev_oe[1]),
		.receive_frame_sync_pin_in(lvl[2]), .receive_frame_sync_pin_out(dev_out[2]),
		.receive_frame_sync_pin_oe(dev_oe[2]), .transmit_clock_pin_in(tx_clk), .port_pin_out(port_out),
		.port_pin_oe(port_oe), .port_pin_level(port_lvl), .tx_timer_out(tmr_out), .tx_timer_irq(tmr_irq)
	);
	srp_peer u_peer (.dev_out(dev_out), .dev_oe(dev_oe), .ext_val(ext_val), .level(lvl));

	// ****************
	// Support tasks
	// ****************
	task summarize();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
		comparisons++;
		if (y !== x) begin
			$display("Error %s expected %h seen %h", nm, x, y);
			err_total++;
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge mclk);
		req.penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) begin
			@(posedge mclk);
		end
		q = prdata;
		e = pslverr;
		req <= '0;
		@(posedge mclk);
	endtask
	task automatic gap();
		int t;
		t = 0;
		while (tmr_irq !== 1'b1 && t < 200) begin
			@(posedge mclk);
			t++;
		end
		n = 0;
		h = 0;
		do begin
			if (tmr_out === 1'b1) h++;
			@(posedge mclk);
			n++;
		end while (tmr_irq !== 1'b1 && n < 200);
	endtask

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_total++;
			summarize();
		end
	end

	// ****************
	// Main sequence
	// ****************
	initial begin
		reset = 1'b1;
		req = '0;
		tx_clk = 1'b0;
		port_out = 3'h0;
		port_oe = 3'h0;
		ext_val = 3'h0;
		rows = '{'{8'h04, 32'hFFFF_FFC4, 32'h0000_0FC4, 1'b0}, '{8'h0C, 32'h1234_5678, 32'h0000_5678, 1'b0},
			'{8'h08, 32'hABCD_0010, 32'h0000_0010, 1'b0}, '{8'h00, 32'hFFFF_F777, 32'h0000_0777, 1'b0},
			'{8'h00, 32'h0000_0888, 32'h0000_0000, 1'b0}, '{8'h10, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		foreach (rows[i]) begin
			apb(rows[i].a, 1'b1, rows[i].d);
			chk("write error", {31'h0, rows[i].e}, {31'h0, e});
			apb(rows[i].a, 1'b0, 32'h0);
			chk("read data", rows[i].q, q);
			chk("read error", {31'h0, rows[i].e}, {31'h0, e});
		end
		for (int k = 0; k < 3; k++) begin
			apb(8'h00, 1'b1, 32'h0000_0006 << (4 * k));
			repeat (6) @(posedge mclk);
			chk("pin enable", 32'(3'h1 << k), {29'h0, dev_oe});
			chk("pin out high", 32'(3'h1 << k), {29'h0, dev_out});
			apb(8'h00, 1'b0, 32'h0);
			chk("pin readback", 32'h0000_000E << (4 * k), q);
			apb(8'h00, 1'b1, 32'h0000_0002 << (4 * k));
			repeat (3) @(posedge mclk);
			chk("pin out low", 32'h0, {29'h0, dev_out});
		end
		ext_val <= 3'h5;
		apb(8'h00, 1'b1, 32'h0);
		repeat (6) @(posedge mclk);
		apb(8'h00, 1'b0, 32'h0);
		chk("input readback", 32'h0000_0808, q);
		chk("inputs released", 32'h0, {29'h0, dev_oe});
		apb(8'h00, 1'b1, 32'h0000_0111);
		port_oe <= 3'h7;
		port_out <= 3'h2;
		repeat (6) @(posedge mclk);
		chk("port enable", 32'h7, {29'h0, dev_oe});
		chk("port out", 32'h2, {29'h0, dev_out});
		chk("port level", 32'h2, {29'h0, port_lvl});
		port_oe <= 3'h0;
		apb(8'h00, 1'b1, 32'h0);
		apb(8'h0C, 1'b1, 32'(PER));
		apb(8'h04, 1'b1, 32'h0000_000B);
		gap();
		gap();
		chk("pulse gap", 32'(2 * PER), 32'(n));
		chk("pulse width", 32'h1, 32'(h));
		apb(8'h04, 1'b1, 32'h0000_000E);
		gap();
		gap();
		chk("clock gap", 32'(4 * PER), 32'(n));
		chk("clock high", 32'(2 * PER), 32'(h));
		apb(8'h04, 1'b1, 32'h0000_000C);
		apb(8'h08, 1'b0, 32'h0);
		q0 = q;
		repeat (10) @(posedge mclk);
		apb(8'h08, 1'b0, 32'h0);
		chk("held count", q0, q);
		apb(8'h08, 1'b1, 32'h0000_0002);
		apb(8'h04, 1'b1, 32'h0000_0003);
		repeat (8) @(posedge mclk);
		apb(8'h04, 1'b0, 32'h0);
		chk("restart pending", 32'h3, q & 32'h0000_000F);
		apb(8'h08, 1'b0, 32'h0);
		chk("count before tick", 32'h2, q);
		tx_clk <= 1'b1;
		repeat (8) @(posedge mclk);
		apb(8'h08, 1'b0, 32'h0);
		chk("count zeroed", 32'h0, q);
		apb(8'h04, 1'b0, 32'h0);
		chk("restart cleared", 32'h2, q & 32'h0000_000F);
		tx_clk <= 1'b0;
		repeat (6) @(posedge mclk);
		tx_clk <= 1'b1;
		repeat (8) @(posedge mclk);
		apb(8'h08, 1'b0, 32'h0);
		chk("count after tick", 32'h1, q);
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		repeat (6) @(posedge mclk);
		chk("reset enables", 32'h0, {29'h0, dev_oe});
		apb(8'h00, 1'b0, 32'h0);
		chk("pin reg reset", 32'h0000_0808, q);
		apb(8'h04, 1'b0, 32'h0);
		chk("timer reg reset", 32'h0, q);
		apb(8'h08, 1'b0, 32'h0);
		chk("count reset", 32'h0, q);
		summarize();
	end
endmodule

bind srp_top srp_chk u_chk (
	.mclk(mclk), .reset(reset), .apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.receive_clock_pin_in(receive_clock_pin_in), .receive_clock_pin_out(receive_clock_pin_out),
	.receive_clock_pin_oe(receive_clock_pin_oe), .receive_data_pin_in(receive_data_pin_in),
	.receive_data_pin_out(receive_data_pin_out), .receive_data_pin_oe(receive_data_pin_oe),
	.receive_frame_sync_pin_in(receive_frame_sync_pin_in), .receive_frame_sync_pin_out(receive_frame_sync_pin_out),
	.receive_frame_sync_pin_oe(receive_frame_sync_pin_oe), .transmit_clock_pin_in(transmit_clock_pin_in),
	.port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .port_pin_level(port_pin_level),
	.tx_timer_out(tx_timer_out), .tx_timer_irq(tx_timer_irq)
);
